// File: src/acc_pkg.sv
// Package: constants and types of the converter control block
`default_nettype none
package acc_pkg;
	localparam int RES_W = 12;
	localparam int GAIN_SEL_W = 3;
	localparam int GAIN_FAC_W = 7;
	localparam int MODE_W = 2;
	// Base conversion latency in converter clock cycles
	localparam int CONV_CYCLES = 7;
	// Extra latency of the gain stage, same for every setting
	localparam int GAIN_EXTRA_CYCLES = 1;
	localparam int CNT_W = 4;
	// Gain select codes
	localparam logic [2:0] GAIN_1X = 3'h0;
	localparam logic [2:0] GAIN_2X = 3'h1;
	localparam logic [2:0] GAIN_4X = 3'h2;
	localparam logic [2:0] GAIN_8X = 3'h3;
	localparam logic [2:0] GAIN_16X = 3'h4;
	localparam logic [2:0] GAIN_32X = 3'h5;
	localparam logic [2:0] GAIN_64X = 3'h6;
	// Compare interrupt mode codes
	localparam logic [1:0] CMP_COMPLETE = 2'h0;
	localparam logic [1:0] CMP_BELOW = 2'h1;
	localparam logic [1:0] CMP_ABOVE = 2'h2;
	// Reset values
	localparam logic [11:0] RESULT_RST = 12'h000;
	localparam logic [6:0] GAIN_FAC_RST = 7'h01;
	typedef enum {ST_IDLE, ST_CONV} acc_state_t;
endpackage
`default_nettype wire

// File: src/acc_cmp_if.sv
// Interface: result compare path between control and compare unit
`default_nettype none
interface acc_cmp_if;
	logic [11:0] code;
	logic [11:0] threshold;
	logic [1:0] mode;
	logic signed_mode;
	logic match;
	modport ctrl (output code, output threshold, output mode, output signed_mode, input match);
	modport cmp (input code, input threshold, input mode, input signed_mode, output match);
endinterface
`default_nettype wire

// File: src/acc_cmp.sv
// Module: threshold compare of a finished conversion result
`default_nettype none
module acc_cmp (
	acc_cmp_if.cmp cmp
);
	// ------------------------------------------------------------
	// Ordering function
	// ------------------------------------------------------------
	function automatic logic is_below(input logic [11:0] a, input logic [11:0] b,
		input logic sgn);
		if (sgn)
		begin
			return $signed(a) < $signed(b);
		end
		return a < b;
	endfunction

	// ------------------------------------------------------------
	// Match decode
	// ------------------------------------------------------------
	always_comb
	begin
		case (cmp.mode)
			acc_pkg::CMP_COMPLETE: cmp.match = 1'b1;
			acc_pkg::CMP_BELOW: cmp.match = is_below(cmp.code, cmp.threshold, cmp.signed_mode);
			acc_pkg::CMP_ABOVE: cmp.match = is_below(cmp.threshold, cmp.code, cmp.signed_mode);
			// Unused mode code never raises the compare interrupt
			default: cmp.match = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// File: src/acc_ctrl.sv
// Module: converter conversion control with gain stage sequencing
//
// Behaviour
// - Single conversion through the gain stage yields an invalid result.
// - Outgoing event fires on every completed conversion, any compare mode.
// - Any gain setting adds exactly one converter clock of latency.
// - Gain factors one to sixty-four in powers of two.
`default_nettype none
module acc_ctrl (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_enable,
	input wire logic i_sw_start,
	input wire logic i_evt_start,
	input wire logic i_free_run,
	input wire logic i_gain_en,
	input wire logic [2:0] i_gain_sel,
	input wire logic i_signed_mode,
	input wire logic [1:0] i_compare_interrupt_mode,
	input wire logic [11:0] i_threshold,
	input wire logic i_cmp_irq_en,
	input wire logic [11:0] i_conv_code,
	output logic o_sample,
	output logic [6:0] o_gain_factor,
	output logic o_busy,
	output logic [11:0] o_result,
	output logic o_result_valid,
	output logic o_done,
	output logic o_event,
	output logic o_cmp_irq
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	acc_pkg::acc_state_t state_reg;
	logic [3:0] cnt_reg;
	logic conv_free_reg;
	logic conv_gain_reg;
	logic sample_reg;
	logic [11:0] result_reg;
	logic result_valid_reg;
	logic done_reg;
	logic event_reg;
	logic cmp_irq_reg;
	logic [6:0] gain_factor_reg;
	logic start_req;
	logic launch;
	logic finish;
	acc_cmp_if cmp_bus ();

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Last count value of a conversion, longer by one with gain
	function automatic logic [3:0] conv_last(input logic gain);
		logic [3:0] len;
		len = 4'(acc_pkg::CONV_CYCLES);
		if (gain)
		begin
			len = len + 4'(acc_pkg::GAIN_EXTRA_CYCLES);
		end
		return len - 4'h1;
	endfunction

	// Gain code to factor; unavailable code falls back to unity
	function automatic logic [6:0] gain_factor(input logic [2:0] sel);
		case (sel)
			acc_pkg::GAIN_1X: return 7'h01;
			acc_pkg::GAIN_2X: return 7'h02;
			acc_pkg::GAIN_4X: return 7'h04;
			acc_pkg::GAIN_8X: return 7'h08;
			acc_pkg::GAIN_16X: return 7'h10;
			acc_pkg::GAIN_32X: return 7'h20;
			acc_pkg::GAIN_64X: return 7'h40;
			default: return 7'h01;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Start and completion decode
	// ------------------------------------------------------------
	assign start_req = i_sw_start | i_evt_start | i_free_run;
	assign launch = (state_reg == acc_pkg::ST_IDLE) && i_enable && start_req;
	assign finish = (state_reg == acc_pkg::ST_CONV) && (cnt_reg == 4'h0);

	// ------------------------------------------------------------
	// Conversion sequencer
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state_reg <= acc_pkg::ST_IDLE;
			cnt_reg <= 4'h0;
			conv_free_reg <= 1'b0;
			conv_gain_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				acc_pkg::ST_IDLE:
				begin
					if (launch)
					begin
						state_reg <= acc_pkg::ST_CONV;
						cnt_reg <= conv_last(i_gain_en);
						conv_free_reg <= i_free_run;
						conv_gain_reg <= i_gain_en;
					end
				end
				acc_pkg::ST_CONV:
				begin
					if (!i_enable)
					begin
						state_reg <= acc_pkg::ST_IDLE;
					end
					else if (finish)
					begin
						if (i_free_run)
						begin
							cnt_reg <= conv_last(i_gain_en);
							conv_free_reg <= 1'b1;
							conv_gain_reg <= i_gain_en;
						end
						else
						begin
							state_reg <= acc_pkg::ST_IDLE;
						end
					end
					else
					begin
						cnt_reg <= cnt_reg - 4'h1;
					end
				end
				default: state_reg <= acc_pkg::ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Sample strobe to the analog core
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			sample_reg <= 1'b0;
		end
		else
		begin
			sample_reg <= launch || (finish && i_enable && i_free_run);
		end
	end

	// ------------------------------------------------------------
	// Gain setting to the analog core
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			gain_factor_reg <= acc_pkg::GAIN_FAC_RST;
		end
		else
		begin
			gain_factor_reg <= i_gain_en ? gain_factor(i_gain_sel) : acc_pkg::GAIN_FAC_RST;
		end
	end

	// ------------------------------------------------------------
	// Result capture
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			result_reg <= acc_pkg::RESULT_RST;
			result_valid_reg <= 1'b0;
		end
		else if (finish && i_enable)
		begin
			result_reg <= i_conv_code;
			result_valid_reg <= !(conv_gain_reg && !conv_free_reg);
		end
	end

	// ------------------------------------------------------------
	// Completion, event and compare outputs
	// ------------------------------------------------------------
	assign cmp_bus.code = i_conv_code;
	assign cmp_bus.threshold = i_threshold;
	assign cmp_bus.mode = i_compare_interrupt_mode;
	assign cmp_bus.signed_mode = i_signed_mode;

	acc_cmp u_cmp (
		.cmp(cmp_bus)
	);

	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			done_reg <= 1'b0;
			event_reg <= 1'b0;
			cmp_irq_reg <= 1'b0;
		end
		else
		begin
			done_reg <= finish && i_enable;
			event_reg <= finish && i_enable;
			// only the interrupt honours the threshold
			cmp_irq_reg <= finish && i_enable && i_cmp_irq_en && cmp_bus.match;
		end
	end

	// Outputs come straight from flip-flops, except o_busy, which is decoded from state_reg
	assign o_sample = sample_reg;
	assign o_gain_factor = gain_factor_reg;
	assign o_busy = (state_reg == acc_pkg::ST_CONV);
	assign o_result = result_reg;
	assign o_result_valid = result_valid_reg;
	assign o_done = done_reg;
	assign o_event = event_reg;
	assign o_cmp_irq = cmp_irq_reg;
endmodule
`default_nettype wire

// File: tb/acc_ctrl_checker.sv
// Checker of the conversion control ports
`default_nettype none
module acc_ctrl_checker (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_enable,
	input wire logic i_free_run,
	input wire logic i_gain_en,
	input wire logic [2:0] i_gain_sel,
	input wire logic o_sample,
	input wire logic [6:0] o_gain_factor,
	input wire logic o_busy,
	input wire logic o_result_valid,
	input wire logic o_done,
	input wire logic o_event
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rstn);
	// ----------------
	// Properties
	// ----------------
	property p_gain_single;
		o_sample && $past(i_gain_en) && !$past(i_free_run) ##8 o_done |-> !o_result_valid;
	endproperty
	a_gain_single: assert property (p_gain_single) else $error("single gain result marked valid");
	property p_evt;
		o_event == o_done;
	endproperty
	a_evt: assert property (p_evt) else $error("event differs from completion");
	// Abort guard: enable must stay high for the whole count
	property p_lat;
		o_sample && i_enable ##1 (i_enable && !o_done)[*6] ##1 i_enable
			|-> o_done == !$past(i_gain_en, 8);
	endproperty
	a_lat: assert property (p_lat) else $error("conversion latency wrong");
	property p_fac;
		$past(i_rstn) |-> o_gain_factor == (($past(i_gain_en) && $past(i_gain_sel) != 3'h7)
			? 7'h01 << $past(i_gain_sel) : 7'h01);
	endproperty
	a_fac: assert property (p_fac) else $error("gain factor wrong");
	property p_restart;
		o_done && $past(i_free_run) && $past(i_enable) |-> o_sample && o_busy;
	endproperty
	a_restart: assert property (p_restart) else $error("free run did not restart");
	cover property (o_done && !o_result_valid);
	cover property (o_done && o_sample);
	cover property (o_gain_factor == 7'h40);
endmodule
bind acc_ctrl acc_ctrl_checker u_chk (.i_sys_clk, .i_rstn, .i_enable, .i_free_run,
	.i_gain_en, .i_gain_sel, .o_sample, .o_gain_factor, .o_busy, .o_result_valid,
	.o_done, .o_event);
`default_nettype wire

// File: tb/acc_analog_model.sv
// Behavioural analog core handing codes to the converter control
`default_nettype none
module acc_analog_model (
	input wire logic i_sys_clk,
	input wire logic i_sample,
	output logic [11:0] o_code
);
	timeunit 1ns;
	timeprecision 1ps;
	// New code per sample; step crosses the sign bit often
	initial o_code = 12'h5a5;
	always @(posedge i_sys_clk)
		if (i_sample)
			o_code <= o_code + 12'h3c7;
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench of the converter control
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk, i_rstn, i_enable, i_sw_start, i_evt_start, i_free_run, i_gain_en;
	logic i_signed_mode, i_cmp_irq_en, o_sample, o_busy, o_result_valid, o_done, o_event, o_cmp_irq;
	logic [2:0] i_gain_sel;
	logic [1:0] i_compare_interrupt_mode;
	logic [11:0] i_threshold, conv_code, o_result;
	logic [6:0] o_gain_factor;
	int n_mismatch = 0;
	int n_checks = 0;
	acc_ctrl DUT (.i_sys_clk, .i_rstn, .i_enable, .i_sw_start, .i_evt_start, .i_free_run,
		.i_gain_en, .i_gain_sel, .i_signed_mode, .i_compare_interrupt_mode, .i_threshold,
		.i_cmp_irq_en, .i_conv_code(conv_code), .o_sample, .o_gain_factor, .o_busy, .o_result,
		.o_result_valid, .o_done, .o_event, .o_cmp_irq);
	acc_analog_model u_model (.i_sys_clk, .i_sample(o_sample), .o_code(conv_code));
	initial
	begin
		i_sys_clk = 1'b0;
		forever #4 i_sys_clk = ~i_sys_clk;
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wait_done(output int n);
		n = 0;
		do
		begin
			@(posedge i_sys_clk);
			#1;
			n++;
		end while (o_done !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			n_mismatch++;
			finish_test();
		end
	endtask
	task automatic conv(input logic evt, input logic gain, input logic [1:0] mode);
		int n;
		logic irq;
		@(posedge i_sys_clk);
		i_gain_en <= gain;
		i_compare_interrupt_mode <= mode;
		i_sw_start <= !evt;
		i_evt_start <= evt;
		@(posedge i_sys_clk);
		i_sw_start <= 1'b0;
		i_evt_start <= 1'b0;
		wait_done(n);
		irq = (mode == 2'h0) || (mode == 2'h1 && $signed(conv_code) < $signed(i_threshold))
			|| (mode == 2'h2 && $signed(conv_code) > $signed(i_threshold));
		check(12'(n), 12'(acc_pkg::CONV_CYCLES + acc_pkg::GAIN_EXTRA_CYCLES * int'(gain)));
		check(o_result, conv_code);
		check({11'h0, o_result_valid}, {11'h0, !gain});
		check({11'h0, o_event}, 12'h001);
		check({11'h0, o_cmp_irq}, {11'h0, irq});
	endtask
	task automatic t_gain;
		for (int s = 0; s < 9; s++)
		begin
			@(posedge i_sys_clk);
			i_gain_en <= (s < 8);
			i_gain_sel <= 3'(s);
			@(posedge i_sys_clk);
			#1;
			check({5'h0, o_gain_factor}, (s == 7 || s == 8) ? 12'h001 : 12'h001 << s);
		end
	endtask
	task automatic t_single;
		@(posedge i_sys_clk);
		i_gain_sel <= acc_pkg::GAIN_64X;
		for (int m = 0; m < 4; m++)
			for (int g = 0; g < 2; g++)
				conv(m[0], g[0], 2'(m));
		// Code above the threshold, so the above mode really matches once
		conv(1'b0, 1'b0, acc_pkg::CMP_ABOVE);
	endtask
	task automatic t_abort;
		logic seen;
		seen = 1'b0;
		@(posedge i_sys_clk);
		i_gain_en <= 1'b0;
		i_sw_start <= 1'b1;
		@(posedge i_sys_clk);
		i_sw_start <= 1'b0;
		repeat (3) @(posedge i_sys_clk);
		#1;
		check({11'h0, o_busy}, 12'h001);
		@(posedge i_sys_clk);
		// Enable dropped before the count ends: no completion may follow
		i_enable <= 1'b0;
		repeat (12)
		begin
			@(posedge i_sys_clk);
			#1;
			seen = seen | o_done | o_event;
		end
		check({11'h0, seen}, 12'h000);
		check({11'h0, o_busy}, 12'h000);
		@(posedge i_sys_clk);
		i_enable <= 1'b1;
	endtask
	task automatic t_free;
		int n;
		@(posedge i_sys_clk);
		i_gain_sel <= acc_pkg::GAIN_8X;
		i_gain_en <= 1'b1;
		// software keeps free run on while the gain stage is used in this test
		i_free_run <= 1'b1;
		// first three results after the switch are dropped
		repeat (3) wait_done(n);
		repeat (3)
		begin
			wait_done(n);
			check(12'(n), 12'h008);
			check({11'h0, o_sample}, 12'h001);
			check({11'h0, o_result_valid}, 12'h001);
			check(o_result, conv_code);
		end
		@(posedge i_sys_clk);
		i_free_run <= 1'b0;
		wait_done(n);
		repeat (2) @(posedge i_sys_clk);
		#1;
		check({11'h0, o_busy}, 12'h000);
	endtask
	initial
	begin
		{i_rstn, i_enable, i_sw_start, i_evt_start, i_free_run, i_gain_en} = 6'h00;
		{i_gain_sel, i_compare_interrupt_mode, i_cmp_irq_en} = 6'h00;
		i_threshold = 12'h000;
		i_signed_mode = 1'b0;
		repeat (6) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		i_enable <= 1'b1;
		// signed result mode also for single-ended use
		i_signed_mode <= 1'b1;
		i_threshold <= 12'h100;
		i_cmp_irq_en <= 1'b1;
		@(posedge i_sys_clk);
		#1;
		check({5'h0, o_gain_factor}, 12'h001);
		t_gain();
		t_single();
		t_abort();
		t_free();
		finish_test();
	end
endmodule
`default_nettype wire
